// file: common/wrwdg_defines.svh
// Constants for the windowed reset watchdog: register map, field
// positions, reset values and timing figures.
// Assumes a 250 MHz system clock and a 32-bit Avalon-MM register bus.
// Overview of operation
// - The 7-bit counter steps down once per 16384-cycle prescaler period.
// - Software picks the timeout in 64 steps via the six low count bits.
// - When active, a count step from 40h to 3Fh starts a reset cycle.
// - A watchdog reset holds the reset line low for about 30 microseconds.
// - The counter keeps counting even while the watchdog is inactive.
// - The unknown prescaler phase at a write gives a timeout range.
// - After any system reset activate is cleared; the watchdog is inactive unless opt_hw_watchdog_i is set.
// - Software cannot clear the activate bit; only a system reset does.
// - Writing activate set with the top counter bit clear resets at once.
// - When active, a HALT instruction gives a reset instead of halting.
// - An option setting selects reset on HALT regardless of software.
// - An option setting can activate the watchdog for good in hardware.
`ifndef WRWDG_DEFINES_SVH
`define WRWDG_DEFINES_SVH

`define WRWDG_ADDR_W         4
`define WRWDG_OFF_CTRL       4'h0
`define WRWDG_OFF_STAT       4'h4
`define WRWDG_ACT_BIT        7
`define WRWDG_TOP_BIT        6
`define WRWDG_CNT_RESET      7'h7F
`define WRWDG_CNT_ROLL_FROM  7'h40
`define WRWDG_PRESCALE       16384
`define WRWDG_CLK_MHZ        250
`define WRWDG_PULSE_US       30
`define WRWDG_PULSE_CYC      (`WRWDG_PULSE_US * `WRWDG_CLK_MHZ)
`define WRWDG_BAD_ADDR_DATA  32'h0000_0000

`endif

// file: common/wrwdg_pkg.sv
// Types shared by the windowed reset watchdog files.
// Assumes nothing beyond the defines header.
package wrwdg_pkg;

    typedef struct packed {
        logic       activate;
        logic [6:0] count;
    } wrwdg_ctrl_t;

    typedef struct packed {
        logic halt_req;
        logic opt_hw_watchdog;
        logic opt_halt_reset;
    } wrwdg_core_in_t;

    typedef enum logic [1:0] {
        WRWDG_IDLE,
        WRWDG_PULSE
    } wrwdg_state_t;

endpackage

// file: rtl/wrwdg_prescaler.sv
// Divider that gives one tick pulse per prescaler period.
// Assumes one system clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "wrwdg_defines.svh"

module wrwdg_prescaler #(
    parameter int DIV = `WRWDG_PRESCALE
) (
    input  wire logic clk_sys_i,   // System clock.
    input  wire logic reset_i,     // Synchronous reset, active high.
    output logic      tick_o       // One-cycle tick per period.
);
    localparam int CW = $clog2(DIV);

    logic [CW-1:0] div_r;

    // The phase is left untouched by register writes, which is what
    // spreads the real timeout between its minimum and maximum.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            div_r  <= '0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= (div_r == CW'(DIV - 1));
            if (div_r == CW'(DIV - 1)) begin
                div_r <= '0;
            end else begin
                div_r <= div_r + CW'(1);
            end
        end
    end

    a_tick_period: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        $rose(tick_o) |=> !tick_o)
        else $error("Prescaler tick lasted more than one cycle.");

endmodule

// file: rtl/wrwdg_top.sv
// Windowed reset watchdog: control register, free-running counter,
// reset pulse generation and option-setting handling.
// Assumes an Avalon-MM master on the system clock and option inputs
// that are static after reset; halt_req_i comes from same-clock logic.
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "wrwdg_defines.svh"

module wrwdg_top #(
    parameter int PRESCALE  = `WRWDG_PRESCALE,
    parameter int PULSE_CYC = `WRWDG_PULSE_CYC
) (
    input  wire logic                      clk_sys_i,         // Clock.
    input  wire logic                      reset_i,           // Sync reset.
    input  wire logic [`WRWDG_ADDR_W-1:0]  avs_address_i,     // Byte addr.
    input  wire logic                      avs_read_i,        // Read req.
    input  wire logic                      avs_write_i,       // Write req.
    input  wire logic [31:0]               avs_writedata_i,   // Write data.
    input  wire logic [3:0]                avs_byteenable_i,  // Lanes.
    output logic [31:0]                    avs_readdata_o,    // Read data.
    output logic                           avs_waitrequest_o, // Stall.
    input  wire logic                      halt_req_i,        // HALT exec.
    input  wire logic                      opt_hw_watchdog_i, // Option.
    input  wire logic                      opt_halt_reset_i,  // Option.
    output logic                           halt_enter_o,      // Go halt.
    output logic                           reset_n_o,         // Reset line.
    output logic                           wdg_active_o       // Active.
);
    import wrwdg_pkg::*;

    localparam int PW = $clog2(PULSE_CYC + 1);

    wrwdg_ctrl_t    ctrl_r;
    wrwdg_core_in_t core_in;
    wrwdg_state_t   state_r;
    logic [PW-1:0]  pulse_cnt_r;
    logic           opt_hw_r;
    logic           opt_halt_r;
    logic           tick;
    logic           access_done_r;
    logic           wr_ctrl;
    logic           active;
    logic           roll_trip;
    logic           sw_trip;
    logic           halt_trip;
    logic           trip;
    logic [6:0]     cnt_nxt;
    logic           req_take;
    logic [PW-1:0]  low_cnt_r;

    assign core_in = '{halt_req:        halt_req_i,
                       opt_hw_watchdog: opt_hw_r,
                       opt_halt_reset:  opt_halt_r};

    wrwdg_prescaler #(
        .DIV       (PRESCALE)
    ) u_prescaler (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .tick_o    (tick)
    );

    // Option settings come from stored settings that stay fixed while
    // the system runs, so one register stage is enough for them.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            opt_hw_r   <= 1'b0;
            opt_halt_r <= 1'b0;
        end else begin
            opt_hw_r   <= opt_hw_watchdog_i;
            opt_halt_r <= opt_halt_reset_i;
        end
    end

    // Every access takes exactly one wait cycle, then completes.
    assign req_take = (avs_read_i || avs_write_i) && !access_done_r;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            access_done_r     <= 1'b0;
            avs_waitrequest_o <= 1'b1;
        end else begin
            access_done_r     <= req_take;
            avs_waitrequest_o <= !req_take;
        end
    end

    assign wr_ctrl = avs_write_i && access_done_r
                     && (avs_address_i == `WRWDG_OFF_CTRL)
                     && avs_byteenable_i[0];
    assign active  = ctrl_r.activate || core_in.opt_hw_watchdog;

    always_comb begin
        cnt_nxt = ctrl_r.count;
        if (wr_ctrl) begin
            cnt_nxt = avs_writedata_i[6:0];
        end else if (tick) begin
            cnt_nxt = ctrl_r.count - 7'h01;
        end
    end

    assign roll_trip = active && tick && !wr_ctrl
                       && (ctrl_r.count == `WRWDG_CNT_ROLL_FROM);
    assign sw_trip   = wr_ctrl && avs_writedata_i[`WRWDG_ACT_BIT]
                       && !avs_writedata_i[`WRWDG_TOP_BIT];
    assign halt_trip = core_in.halt_req
                       && (active || core_in.opt_halt_reset);
    assign trip      = roll_trip || sw_trip || halt_trip;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ctrl_r.activate <= 1'b0;
            ctrl_r.count    <= `WRWDG_CNT_RESET;
        end else begin
            ctrl_r.count <= cnt_nxt;
            if (wr_ctrl && avs_writedata_i[`WRWDG_ACT_BIT]) begin
                ctrl_r.activate <= 1'b1;
            end
        end
    end

    // Reset pulse sequencer; ignores new trips while the pulse is running.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_r     <= WRWDG_IDLE;
            pulse_cnt_r <= '0;
            reset_n_o   <= 1'b1;
        end else begin
            unique case (state_r)
                WRWDG_IDLE: begin
                    if (trip) begin
                        state_r     <= WRWDG_PULSE;
                        pulse_cnt_r <= PW'(PULSE_CYC - 1);
                        reset_n_o   <= 1'b0;
                    end
                end
                WRWDG_PULSE: begin
                    if (pulse_cnt_r == '0) begin
                        state_r   <= WRWDG_IDLE;
                        reset_n_o <= 1'b1;
                    end else begin
                        pulse_cnt_r <= pulse_cnt_r - PW'(1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            halt_enter_o <= 1'b0;
            wdg_active_o <= 1'b0;
        end else begin
            halt_enter_o <= core_in.halt_req && !halt_trip;
            wdg_active_o <= active;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !access_done_r) begin
            unique case (avs_address_i)
                `WRWDG_OFF_CTRL: avs_readdata_o <= {24'h00_0000,
                                    ctrl_r};
                `WRWDG_OFF_STAT: avs_readdata_o <= {29'h0000_0000,
                                    !reset_n_o, active, opt_halt_r};
                default:         avs_readdata_o <= `WRWDG_BAD_ADDR_DATA;
            endcase
        end
    end

    // Counts the cycles for which the reset line has been low, so that
    // the full pulse length is checked without a long unrolled delay.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            low_cnt_r <= '0;
        end else if (!reset_n_o) begin
            low_cnt_r <= low_cnt_r + PW'(1);
        end else begin
            low_cnt_r <= '0;
        end
    end

    sequence s_roll_seen;
        active && tick && !wr_ctrl
            && ctrl_r.count == `WRWDG_CNT_ROLL_FROM && state_r == WRWDG_IDLE;
    endsequence

    sequence s_pulse_low;
        !reset_n_o [*8];
    endsequence

    sequence s_bus_take;
        (avs_read_i || avs_write_i) && !access_done_r;
    endsequence

    sequence s_halt_opt;
        halt_req_i && opt_halt_r && state_r == WRWDG_IDLE;
    endsequence

    a_roll_resets: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        s_roll_seen
        |=> s_pulse_low)
        else $error("Counter rollover did not start a reset pulse.");

    a_pulse_length: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        $rose(reset_n_o)
        |-> low_cnt_r == PW'(PULSE_CYC))
        else $error("Reset pulse length is wrong.");

    a_pulse_bound: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        !reset_n_o
        |-> low_cnt_r < PW'(PULSE_CYC))
        else $error("Reset pulse ran too long.");

    a_pulse_holds: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        state_r == WRWDG_PULSE && pulse_cnt_r != '0
        |=> !reset_n_o)
        else $error("Reset pulse ended early.");

    a_no_idle_reset: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        state_r == WRWDG_IDLE && !trip
        |=> reset_n_o)
        else $error("Reset line went low with no cause.");

    a_active_sticky: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        ctrl_r.activate
        |=> ctrl_r.activate)
        else $error("Activate bit cleared without a reset.");

    a_sw_activates: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        wr_ctrl && avs_writedata_i[`WRWDG_ACT_BIT]
        |=> ctrl_r.activate)
        else $error("Write did not set the activate bit.");

    a_count_free: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        tick && !wr_ctrl
        |=> ctrl_r.count == $past(ctrl_r.count) - 7'h01)
        else $error("Counter did not step down on a tick.");

    a_count_hold: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        !tick && !wr_ctrl
        |=> ctrl_r.count == $past(ctrl_r.count))
        else $error("Counter moved without a tick.");

    a_write_loads: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        wr_ctrl
        |=> ctrl_r.count == $past(avs_writedata_i[6:0]))
        else $error("Write did not load the counter.");

    a_sw_reset: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        sw_trip && state_r == WRWDG_IDLE
        |=> !reset_n_o)
        else $error("Software reset write did not pull reset low.");

    a_halt_reset: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        halt_req_i && active
        |=> !halt_enter_o)
        else $error("HALT entered while the watchdog was active.");

    a_halt_passes: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        halt_req_i && !active && !opt_halt_r
        |=> halt_enter_o)
        else $error("HALT refused while the watchdog was inactive.");

    a_halt_option: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        s_halt_opt
        |=> !reset_n_o)
        else $error("HALT option did not pull reset low.");

    a_hw_option: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        opt_hw_r
        |=> wdg_active_o)
        else $error("Hardware option did not activate the watchdog.");

    a_active_out: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        1'b1
        |=> wdg_active_o == $past(active))
        else $error("Active output does not follow the active state.");

    a_come_up_idle: assert property (
        @(posedge clk_sys_i)
        $fell(reset_i)
        |-> !ctrl_r.activate && reset_n_o)
        else $error("Watchdog not inactive after reset.");

    a_wait_release: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        s_bus_take
        |=> !avs_waitrequest_o)
        else $error("Access was not answered after one wait cycle.");

    a_wait_single: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        !avs_waitrequest_o
        |=> avs_waitrequest_o)
        else $error("Waitrequest stayed low for more than one cycle.");

    a_idle_waits: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        !avs_read_i && !avs_write_i
        |=> avs_waitrequest_o)
        else $error("Waitrequest low with no access pending.");

    a_read_count: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        s_bus_take && avs_read_i && avs_address_i == `WRWDG_OFF_CTRL
        |=> avs_readdata_o[6:0] == $past(ctrl_r.count))
        else $error("Control read did not return the count.");

    a_read_activate: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        s_bus_take && avs_read_i && avs_address_i == `WRWDG_OFF_CTRL
        |=> avs_readdata_o[7] == $past(ctrl_r.activate))
        else $error("Control read did not return the activate bit.");

    a_read_unmapped: assert property (
        @(posedge clk_sys_i) disable iff (reset_i)
        s_bus_take && avs_read_i && avs_address_i != `WRWDG_OFF_CTRL
            && avs_address_i != `WRWDG_OFF_STAT
        |=> avs_readdata_o == `WRWDG_BAD_ADDR_DATA)
        else $error("Unmapped read returned nonzero data.");

endmodule

// file: tb/tb.sv
// Self-checking bench for the windowed reset watchdog top.
// Assumes wrwdg_top with a shortened prescaler and reset pulse.
`timescale 1ns/1ps
`include "wrwdg_defines.svh"

module tb;
    localparam int PS = 8;
    localparam int PW = 10;
    logic        clk_sys_i = 1'b0;
    logic        reset_i   = 1'b1;
    logic        rd        = 1'b0;
    logic        wr        = 1'b0;
    logic [3:0]  adr       = 4'h0;
    logic [31:0] wdat      = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        wt;
    logic        halt      = 1'b0;
    logic        opt_hw    = 1'b0;
    logic        opt_hr    = 1'b0;
    logic        henter;
    logic        rst_n;
    logic        act;
    logic        he;
    logic        rl;
    int          errors    = 0;
    int          n_tests   = 0;
    int          t;
    int          w;

    always #2 clk_sys_i = ~clk_sys_i;

    wrwdg_top #(.PRESCALE(PS), .PULSE_CYC(PW)) dut (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .halt_req_i(halt),
        .opt_hw_watchdog_i(opt_hw), .opt_halt_reset_i(opt_hr),
        .halt_enter_o(henter), .reset_n_o(rst_n), .wdg_active_o(act));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Waitrequest and read data are taken at the rising edge itself,
    // before that edge's updates land.
    task automatic bus(input logic we, input logic [3:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        adr <= a;
        wr <= we;
        rd <= ~we;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (wt !== 1'b0 && n < 50);
        q = rdat;
        if (n >= 50) errors++;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic trip(output int tf, output int tw);
        tf = 0;
        tw = 0;
        while (rst_n !== 1'b0 && tf < 300) begin
            @(negedge clk_sys_i);
            tf++;
        end
        while (rst_n === 1'b0 && tw < 300) begin
            @(negedge clk_sys_i);
            tw++;
        end
    endtask

    task automatic do_reset;
        @(posedge clk_sys_i);
        reset_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        reset_i <= 1'b0;
    endtask

    task automatic halt_try(output logic h, output logic r);
        @(posedge clk_sys_i);
        halt <= 1'b1;
        @(posedge clk_sys_i);
        halt <= 1'b0;
        h = 1'b0;
        r = 1'b0;
        repeat (3) begin
            @(negedge clk_sys_i);
            h = h | (henter === 1'b1);
            r = r | (rst_n === 1'b0);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        errors++;
        give_verdict();
    end

    initial begin
        do_reset();
        bus(1'b0, 4'h0, 8'h00);
        chk({31'h0, q[7]}, 32'h0);
        chk({31'h0, act}, 32'h0);
        bus(1'b1, 4'h0, 8'h50);
        repeat (40) @(posedge clk_sys_i);
        bus(1'b0, 4'h0, 8'h00);
        chk(q, 32'h4B);
        bus(1'b1, 4'h0, 8'h00);
        trip(t, w);
        chk(t, 300);
        bus(1'b0, 4'h8, 8'h00);
        chk(q, 32'h0);
        $display("test counting done");
        bus(1'b1, 4'h0, 8'hC5);
        bus(1'b1, 4'h0, 8'h45);
        chk({31'h0, act}, 32'h1);
        bus(1'b0, 4'h0, 8'h00);
        chk({31'h0, q[7]}, 32'h1);
        trip(t, w);
        chk({31'h0, t >= 38 && t <= 49}, 32'h1);
        chk(w, PW);
        do_reset();
        @(negedge clk_sys_i);
        chk({31'h0, act}, 32'h0);
        for (int m = 0; m < 3; m += 2) begin
            bus(1'b1, 4'h0, 8'hC0 | m[7:0]);
            trip(t, w);
            chk({31'h0, t >= 8 * m + 1 && t <= 8 * m + 8}, 32'h1);
            do_reset();
        end
        $display("test timeout done");
        bus(1'b1, 4'h0, 8'h80);
        trip(t, w);
        chk(t, 1);
        do_reset();
        repeat (4) begin
            bus(1'b1, 4'h0, 8'hC2);
            repeat (10) @(posedge clk_sys_i);
            chk({31'h0, rst_n}, 32'h1);
        end
        do_reset();
        halt_try(he, rl);
        chk({30'h0, he, rl}, 32'h2);
        bus(1'b1, 4'h0, 8'hFF);
        halt_try(he, rl);
        chk({30'h0, he, rl}, 32'h1);
        do_reset();
        $display("test halt done");
        opt_hr <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        halt_try(he, rl);
        chk({30'h0, he, rl}, 32'h1);
        do_reset();
        bus(1'b0, 4'h4, 8'h00);
        chk(q & 32'h1, 32'h1);
        opt_hr <= 1'b0;
        opt_hw <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        chk({31'h0, act}, 32'h1);
        bus(1'b0, 4'h4, 8'h00);
        chk(q & 32'h2, 32'h2);
        opt_hw <= 1'b0;
        do_reset();
        $display("test options done");
        give_verdict();
    end
endmodule
